// ===== rmc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rmc_host_model (
   // Device pins
   input  wire logic bit_clk_i,
   input  wire logic data_o_i,
   input  wire logic data_oe_i,
   input  wire logic host_bit_i,
   // Resolved wire and capture
   output logic      data_wire_o,
   output logic      last_bit_o
);
   // Host only drives the shared line while the device lets go of it
   assign data_wire_o = data_oe_i ? data_o_i : host_bit_i;
   // Sample at the rising recovered clock, where data is settled
   always @(posedge bit_clk_i) last_bit_o <= data_wire_o;
endmodule
`default_nettype wire

// ===== rmc_pkg.sv
package rmc_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] RMC_OFS_MODE    = 8'h00;
   localparam logic [7:0] RMC_OFS_DCFG    = 8'h04;
   localparam logic [7:0] RMC_OFS_OOKLVL  = 8'h08;
   localparam logic [7:0] RMC_OFS_FIFOCFG = 8'h0C;
   localparam logic [7:0] RMC_OFS_LOCK    = 8'h10;
   localparam logic [7:0] RMC_OFS_RXCFG   = 8'h14;
   localparam logic [7:0] RMC_OFS_STATUS  = 8'h18;
   localparam logic [7:0] RMC_OFS_FIFODAT = 8'h1C;
   localparam logic [7:0] RMC_OFS_RSSI    = 8'h20;
   // Field positions
   localparam int RMC_MODE_LSB     = 5;
   localparam int RMC_BUFSEL_BIT   = 5;
   localparam int RMC_OOKM_LSB     = 3;
   localparam int RMC_PKT_BIT      = 2;
   localparam int RMC_FSK_BIT      = 0;
   localparam int RMC_DEPTH_LSB    = 6;
   localparam int RMC_THR_LSB      = 0;
   localparam int RMC_LOCKEN_BIT   = 0;
   localparam int RMC_LOCKST_BIT   = 1;
   localparam int RMC_RECDIS_BIT   = 6;
   // Reset values
   localparam logic [2:0] RMC_MODE_RST   = 3'h0;
   localparam logic       RMC_LOCKEN_RST = 1'b1;
   localparam logic [1:0] RMC_DEPTH_RST  = 2'h3;
   localparam logic [5:0] RMC_THR_RST    = 6'h20;
   localparam logic [7:0] RMC_OOKLVL_RST = 8'h40;
   // Chip state codes
   localparam logic [2:0] RMC_ST_SLEEP = 3'h0;
   localparam logic [2:0] RMC_ST_STBY  = 3'h1;
   localparam logic [2:0] RMC_ST_SYNTH = 3'h2;
   localparam logic [2:0] RMC_ST_RX    = 3'h3;
   localparam logic [2:0] RMC_ST_TX    = 3'h4;
   // OOK threshold methods
   localparam logic [1:0] RMC_OOK_FIXED = 2'h0;
   localparam logic [1:0] RMC_OOK_PEAK  = 2'h1;
   localparam logic [1:0] RMC_OOK_AVG   = 2'h2;
   // Timing and sizing
   localparam int          RMC_CLK_HZ       = 10_000_000;
   localparam int          RMC_BIT_RATE_BPS = 25_000;
   localparam int          RMC_BIT_CYCLES   = RMC_CLK_HZ / RMC_BIT_RATE_BPS;
   localparam int          RMC_FIFO_BYTES   = 64;
   localparam int          RMC_BANK_BYTES   = 16;
   localparam logic [7:0]  RMC_PEAK_OFFSET  = 8'h0C;
   typedef enum logic [1:0] {RMC_PK_IDLE, RMC_PK_LEN, RMC_PK_BODY} rmc_pkt_t;
endpackage

// ===== rmc_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rmc_chk (
   // Clock, reset and selects
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic pll_locked_i,
   input wire logic config_port_select_n_i,
   input wire logic buffer_port_select_n_i,
   // Observed outputs
   input wire logic xtal_en_o,
   input wire logic synth_en_o,
   input wire logic rx_en_o,
   input wire logic tx_en_o,
   input wire logic lock_pin_o,
   input wire logic irq_pin_a_oe_o,
   input wire logic irq_pin_b_o,
   input wire logic irq_pin_b_oe_o,
   input wire logic data_pin_o,
   input wire logic data_pin_oe_o,
   input wire logic reference_clock_output_oe_o,
   input wire logic sdo_oe_o,
   input wire logic sdo_from_buffer_o,
   input wire logic tx_bit_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Sync chain is three flops, so eight low samples must clear the pin
   chk_lock_pin_low: assert property (!pll_locked_i [*8] |-> !lock_pin_o)
      else $error("lock pin high without lock");
   chk_sleep_float: assert property (!xtal_en_o && $past(!xtal_en_o) |->
      !(irq_pin_a_oe_o | irq_pin_b_oe_o | data_pin_oe_o | reference_clock_output_oe_o))
      else $error("pin driven in sleep");
   chk_awake_drive: assert property (xtal_en_o && $past(xtal_en_o) |->
      irq_pin_a_oe_o && irq_pin_b_oe_o && reference_clock_output_oe_o)
      else $error("pin floating while awake");
   chk_enable_chain: assert property ((synth_en_o |-> xtal_en_o) and
      (rx_en_o || tx_en_o |-> synth_en_o && !(rx_en_o && tx_en_o)))
      else $error("function enables inconsistent");
   chk_data_float: assert property (data_pin_oe_o |-> rx_en_o || $past(rx_en_o))
      else $error("data pin driven outside receive");
   chk_sdo_idle: assert property (config_port_select_n_i && buffer_port_select_n_i &&
      $past(config_port_select_n_i && buffer_port_select_n_i) |-> !sdo_oe_o)
      else $error("serial out driven with no select");
   chk_sdo_priority: assert property (!config_port_select_n_i &&
      $past(!config_port_select_n_i) |-> sdo_oe_o && !sdo_from_buffer_o)
      else $error("config select lost priority");
   chk_tx_input: assert property (!tx_en_o && $past(!tx_en_o) |-> !tx_bit_o)
      else $error("transmit bit outside transmit");
   chk_bit_stable: assert property ($rose(irq_pin_b_o) && data_pin_oe_o |->
      $stable(data_pin_o))
      else $error("data moved at clock rise");
endmodule
bind rmc_radio_ctrl rmc_chk u_chk (.*);
`default_nettype wire

// ===== rmc_radio_ctrl.sv
// Function
// - Lock pin follows PLL lock while lock indicator enable is set.
// - Lock sticky bit sets on every lock; host writes one to clear.
// - Chip state field bits 7..5: sleep, standby, synth, receive, transmit.
// - Each chip state enables oscillator, synthesizer, receiver or transmitter cumulatively.
// - Sleep floats irq pins, data and clock out; others drive irq pins and clock out.
// - Data pin floats except continuous receive (driven) and continuous transmit (input).
// - Serial out driven while either select low; config select wins.
// - Continuous, buffered and packet data handling modes.
// - Packet mode strips the leading length byte and keeps payload.
// - Working buffer length 16, 32, 48 or 64 bytes from depth field.
// - Receive level flag rises when count reaches threshold or above.
// - Transmit level flag rises when count is at or below threshold.
// - Continuous receive: recovered clock on irq b, bits on data pin.
// - Recovery disable holds clock low and passes raw demodulator bit.
// - Recovered data is stable at each rising recovered clock edge.
// - OOK compares strength with fixed, peak-offset or average threshold.
// - FSK decides bits from phase of limited I and Q signals.
`timescale 1ns/1ns
`default_nettype none
module rmc_radio_ctrl
   import rmc_pkg::*;
#(
   parameter int BIT_CYCLES  = RMC_BIT_CYCLES,
   parameter int REFCLK_DIV  = 4
) (
   // Clock and reset
   input  wire  logic        sys_clk_i,
   input  wire  logic        reset_n_i,
   // AHB-Lite slave
   input  wire  logic        hsel_i,
   input  wire  logic [31:0] haddr_i,
   input  wire  logic [1:0]  htrans_i,
   input  wire  logic        hwrite_i,
   input  wire  logic [2:0]  hsize_i,
   input  wire  logic        hready_i,
   input  wire  logic [31:0] hwdata_i,
   output logic [31:0]       hrdata_o,
   output logic              hreadyout_o,
   output logic              hresp_o,
   // Analog and pin inputs
   input  wire  logic        pll_locked_i,
   input  wire  logic        i_limited_i,
   input  wire  logic        q_limited_i,
   input  wire  logic [7:0]  signal_strength_value_i,
   input  wire  logic        config_port_select_n_i,
   input  wire  logic        buffer_port_select_n_i,
   // Function enables
   output logic              xtal_en_o,
   output logic              synth_en_o,
   output logic              rx_en_o,
   output logic              tx_en_o,
   // Pins
   output logic              lock_pin_o,
   output logic              irq_pin_a_o,
   output logic              irq_pin_a_oe_o,
   output logic              irq_pin_b_o,
   output logic              irq_pin_b_oe_o,
   input  wire  logic        data_pin_i,
   output logic              data_pin_o,
   output logic              data_pin_oe_o,
   output logic              reference_clock_output_o,
   output logic              reference_clock_output_oe_o,
   output logic              sdo_oe_o,
   output logic              sdo_from_buffer_o,
   // Transmit data toward the modulator
   output logic              tx_bit_o,
   output logic [7:0]        tx_byte_o,
   output logic              tx_byte_valid_o,
   input  wire  logic        tx_byte_ready_i
);
   localparam int HALF = BIT_CYCLES / 2;
   localparam int CW   = $clog2(BIT_CYCLES + 1);

   // Registers
   logic [2:0]  chip_state_select_ff;
   logic        buffered_path_select_ff;
   logic [1:0]  ook_threshold_method_ff;
   logic        packet_mode_ff;
   logic        fsk_select_ff;
   logic [7:0]  ook_fixed_level_ff;
   logic [1:0]  buffer_length_select_ff;
   logic [5:0]  buffer_level_threshold_ff;
   logic        lock_indicator_enable_ff;
   logic        lock_sticky_status_ff;
   logic        recovery_disable_ff;
   // Bus phase
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic        rd_pop_ff;
   // Synchronised pins
   logic [3:0]  sync1_ff;
   logic [3:0]  sync2_ff;
   logic [3:0]  sync3_ff;
   logic [3:0]  pin_ff;
   logic        lock_prev_ff;
   // Demodulation and recovery
   logic        i_prev_ff;
   logic        fsk_bit_ff;
   logic [7:0]  peak_ff;
   logic [7:0]  avg_ff;
   logic        raw_prev_ff;
   logic [CW-1:0] bit_cnt_ff;
   logic        rec_data_ff;
   logic        rec_clk_ff;
   logic [7:0]  shift_ff;
   logic [2:0]  nbits_ff;
   logic        byte_stb_ff;
   rmc_pkt_t    pkt_state_ff;
   logic [7:0]  pkt_left_ff;
   // Buffer storage
   logic [7:0]  fifo_mem [RMC_FIFO_BYTES];
   logic [5:0]  wr_ptr_ff;
   logic [5:0]  rd_ptr_ff;
   logic [6:0]  count_ff;
   logic        rx_level_ff;
   logic        tx_level_ff;
   // Two-entry output buffer
   logic [7:0]  skid_data_ff [2];
   logic [1:0]  skid_cnt_ff;
   logic        skid_rd_ff;
   logic [15:0] ref_cnt_ff;

   // Decode and combinational terms
   logic        addr_ok;
   logic        wr_now;
   logic [7:0]  wd;
   logic        state_rx;
   logic        state_tx;
   logic        raw_bit;
   logic [7:0]  ook_thr;
   logic [6:0]  fifo_len;
   logic        fifo_full;
   logic        push;
   logic        pop_bus;
   logic        pop_tx;
   logic        pop;
   logic        store_byte;
   logic [31:0] rd_mux;
   logic        take;

   assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
   assign wr_now   = wr_pend_ff;
   assign wd       = hwdata_i[7:0];
   assign state_rx = (chip_state_select_ff == RMC_ST_RX);
   assign state_tx = (chip_state_select_ff == RMC_ST_TX);
   // Length in 16-byte banks
   assign fifo_len  = 7'((buffer_length_select_ff + 3'h1) * RMC_BANK_BYTES);
   assign fifo_full = (count_ff >= fifo_len);

   // Pin synchronisers: a change counts once stages two and three agree
   generate
      for (genvar g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (!reset_n_i) begin
               sync1_ff[g] <= 1'b0;
               sync2_ff[g] <= 1'b0;
               sync3_ff[g] <= 1'b0;
               pin_ff[g]   <= 1'b0;
            end else begin
               sync1_ff[g] <= (g == 0) ? pll_locked_i : (g == 1) ? i_limited_i :
                              (g == 2) ? q_limited_i : data_pin_i;
               sync2_ff[g] <= sync1_ff[g];
               sync3_ff[g] <= sync2_ff[g];
               if (sync2_ff[g] == sync3_ff[g]) begin
                  pin_ff[g] <= sync3_ff[g];
               end
            end
         end
      end
   endgenerate

   // AHB address phase: latch writes, answer reads with zero wait states
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= 8'h00;
         rd_pop_ff   <= 1'b0;
         hrdata_o    <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         wr_pend_ff  <= addr_ok && hwrite_i;
         wr_addr_ff  <= haddr_i[7:0];
         rd_pop_ff   <= 1'b0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (addr_ok && !hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   // Read multiplexer; unmapped words read as zero
   always_comb begin
      rd_mux  = 32'h0000_0000;
      pop_bus = 1'b0;
      case (haddr_i[7:0])
         RMC_OFS_MODE:    rd_mux[7:RMC_MODE_LSB] = chip_state_select_ff;
         RMC_OFS_DCFG:    rd_mux[7:0] = {2'b00, buffered_path_select_ff,
                                         ook_threshold_method_ff, packet_mode_ff,
                                         1'b0, fsk_select_ff};
         RMC_OFS_OOKLVL:  rd_mux[7:0] = ook_fixed_level_ff;
         RMC_OFS_FIFOCFG: rd_mux[7:0] = {buffer_length_select_ff, buffer_level_threshold_ff};
         RMC_OFS_LOCK:    rd_mux[7:0] = {6'h00, lock_sticky_status_ff,
                                         lock_indicator_enable_ff};
         RMC_OFS_RXCFG:   rd_mux[RMC_RECDIS_BIT] = recovery_disable_ff;
         RMC_OFS_STATUS:  rd_mux[15:0] = {count_ff, tx_level_ff, rx_level_ff,
                                          fifo_full, (count_ff != 7'h00),
                                          pin_ff[0], pkt_state_ff, 2'b00};
         RMC_OFS_RSSI:    rd_mux[7:0] = signal_strength_value_i;
         RMC_OFS_FIFODAT: begin
            rd_mux[7:0] = fifo_mem[rd_ptr_ff];
            pop_bus     = addr_ok && !hwrite_i && (count_ff != 7'h00) && !skid_rd_ff;
         end
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Configuration writes in the data phase
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         chip_state_select_ff      <= RMC_MODE_RST;
         buffered_path_select_ff   <= 1'b0;
         ook_threshold_method_ff   <= RMC_OOK_FIXED;
         packet_mode_ff            <= 1'b0;
         fsk_select_ff             <= 1'b1;
         ook_fixed_level_ff        <= RMC_OOKLVL_RST;
         buffer_length_select_ff   <= RMC_DEPTH_RST;
         buffer_level_threshold_ff <= RMC_THR_RST;
         lock_indicator_enable_ff  <= RMC_LOCKEN_RST;
         recovery_disable_ff       <= 1'b0;
      end else if (wr_now) begin
         case (wr_addr_ff)
            RMC_OFS_MODE: begin
               if (wd[7:RMC_MODE_LSB] <= RMC_ST_TX) begin
                  chip_state_select_ff <= wd[7:RMC_MODE_LSB];
               end
            end
            RMC_OFS_DCFG: begin
               buffered_path_select_ff <= wd[RMC_BUFSEL_BIT];
               ook_threshold_method_ff <= wd[RMC_OOKM_LSB +: 2];
               packet_mode_ff          <= wd[RMC_PKT_BIT];
               fsk_select_ff           <= wd[RMC_FSK_BIT];
            end
            RMC_OFS_OOKLVL:  ook_fixed_level_ff <= wd;
            RMC_OFS_FIFOCFG: begin
               buffer_length_select_ff   <= wd[RMC_DEPTH_LSB +: 2];
               buffer_level_threshold_ff <= wd[RMC_THR_LSB +: 6];
            end
            RMC_OFS_LOCK:  lock_indicator_enable_ff <= wd[RMC_LOCKEN_BIT];
            RMC_OFS_RXCFG: recovery_disable_ff <= wd[RMC_RECDIS_BIT];
            default: ;
         endcase
      end
   end

   // Lock pin and sticky lock status; a new lock beats a same-cycle clear
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         lock_prev_ff          <= 1'b0;
         lock_sticky_status_ff <= 1'b0;
         lock_pin_o            <= 1'b0;
      end else begin
         lock_prev_ff <= pin_ff[0];
         lock_pin_o   <= lock_indicator_enable_ff && pin_ff[0];
         if (pin_ff[0] && !lock_prev_ff) begin
            lock_sticky_status_ff <= 1'b1;
         end else if (wr_now && wr_addr_ff == RMC_OFS_LOCK && wd[RMC_LOCKST_BIT]) begin
            lock_sticky_status_ff <= 1'b0;
         end
      end
   end

   // Function enables per chip state
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         xtal_en_o  <= 1'b0;
         synth_en_o <= 1'b0;
         rx_en_o    <= 1'b0;
         tx_en_o    <= 1'b0;
      end else begin
         xtal_en_o  <= (chip_state_select_ff != RMC_ST_SLEEP);
         synth_en_o <= (chip_state_select_ff >= RMC_ST_SYNTH);
         rx_en_o    <= state_rx;
         tx_en_o    <= state_tx;
      end
   end

   // Demodulator: FSK from I/Q phase, OOK from strength against threshold
   always_comb begin
      case (ook_threshold_method_ff)
         RMC_OOK_FIXED: ook_thr = ook_fixed_level_ff;
         RMC_OOK_PEAK:  ook_thr = (peak_ff > RMC_PEAK_OFFSET) ?
                                  8'(peak_ff - RMC_PEAK_OFFSET) : 8'h00;
         RMC_OOK_AVG:   ook_thr = avg_ff;
         default:       ook_thr = ook_fixed_level_ff;
      endcase
      raw_bit = fsk_select_ff ? fsk_bit_ff : (signal_strength_value_i > ook_thr);
   end

   // FSK: Q level at each rising I edge tells which way the phase turns
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         i_prev_ff  <= 1'b0;
         fsk_bit_ff <= 1'b0;
         peak_ff    <= 8'h00;
         avg_ff     <= 8'h00;
      end else begin
         i_prev_ff <= pin_ff[1];
         if (pin_ff[1] && !i_prev_ff) begin
            fsk_bit_ff <= pin_ff[2];
         end
         // Peak only grows while receiving; it restarts outside receive
         peak_ff <= !state_rx ? 8'h00 :
                    (signal_strength_value_i > peak_ff) ? signal_strength_value_i : peak_ff;
         avg_ff  <= 8'(({2'b00, avg_ff, 3'b000} - {5'h00, avg_ff} +
                        {5'h00, signal_strength_value_i}) >> 3);
      end
   end

   // Clock recovery: realign on each raw edge, update data mid-bit, clock rises after
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         raw_prev_ff <= 1'b0;
         bit_cnt_ff  <= '0;
         rec_data_ff <= 1'b0;
         rec_clk_ff  <= 1'b0;
         shift_ff    <= 8'h00;
         nbits_ff    <= 3'h0;
         byte_stb_ff <= 1'b0;
      end else begin
         raw_prev_ff <= raw_bit;
         byte_stb_ff <= 1'b0;
         if (raw_bit != raw_prev_ff || bit_cnt_ff == CW'(BIT_CYCLES - 1)) begin
            bit_cnt_ff <= '0;
         end else begin
            bit_cnt_ff <= bit_cnt_ff + CW'(1);
         end
         if (recovery_disable_ff) begin
            rec_data_ff <= raw_bit;
            rec_clk_ff  <= 1'b0;
         end else begin
            rec_clk_ff <= (bit_cnt_ff > CW'(HALF));
            if (bit_cnt_ff == CW'(HALF) && state_rx) begin
               rec_data_ff <= raw_bit;
               shift_ff    <= {shift_ff[6:0], raw_bit};
               nbits_ff    <= nbits_ff + 3'h1;
               byte_stb_ff <= (nbits_ff == 3'h7) && buffered_path_select_ff;
            end
         end
      end
   end

   // Packet extraction: length byte first, then that many payload bytes kept
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         pkt_state_ff <= RMC_PK_IDLE;
         pkt_left_ff  <= 8'h00;
      end else begin
         case (pkt_state_ff)
            RMC_PK_IDLE: begin
               if (packet_mode_ff && state_rx) begin
                  pkt_state_ff <= RMC_PK_LEN;
               end
            end
            RMC_PK_LEN: begin
               if (!packet_mode_ff || !state_rx) begin
                  pkt_state_ff <= RMC_PK_IDLE;
               end else if (byte_stb_ff && shift_ff != 8'h00) begin
                  pkt_left_ff  <= shift_ff;
                  pkt_state_ff <= RMC_PK_BODY;
               end
            end
            RMC_PK_BODY: begin
               if (!packet_mode_ff || !state_rx) begin
                  pkt_state_ff <= RMC_PK_IDLE;
               end else if (byte_stb_ff) begin
                  pkt_left_ff <= pkt_left_ff - 8'h01;
                  if (pkt_left_ff == 8'h01) begin
                     pkt_state_ff <= RMC_PK_LEN;
                  end
               end
            end
            default: pkt_state_ff <= RMC_PK_IDLE;
         endcase
      end
   end

   // Buffer fill from receiver or bus, drained by bus reads or transmit path
   assign store_byte = byte_stb_ff && (!packet_mode_ff || pkt_state_ff == RMC_PK_BODY);
   assign push   = !fifo_full && ((state_rx && store_byte) ||
                   (!state_rx && wr_now && wr_addr_ff == RMC_OFS_FIFODAT));
   assign pop_tx = state_tx && buffered_path_select_ff && (count_ff != 7'h00) &&
                   (skid_cnt_ff != 2'h2) && !pop_bus;
   assign pop    = pop_bus || pop_tx;
   assign take   = tx_byte_valid_o && tx_byte_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         fifo_mem[wr_ptr_ff] <= state_rx ? shift_ff : wd;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wr_ptr_ff   <= 6'h00;
         rd_ptr_ff   <= 6'h00;
         count_ff    <= 7'h00;
         rx_level_ff <= 1'b0;
         tx_level_ff <= 1'b0;
         skid_rd_ff  <= 1'b0;
      end else begin
         skid_rd_ff <= pop_bus;
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == 6'(fifo_len - 7'h01)) ? 6'h00 : wr_ptr_ff + 6'h01;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == 6'(fifo_len - 7'h01)) ? 6'h00 : rd_ptr_ff + 6'h01;
         end
         count_ff <= count_ff + 7'(push) - 7'(pop);
         // Levels track count and threshold every cycle, so edges appear on entry
         rx_level_ff <= (count_ff >= {1'b0, buffer_level_threshold_ff});
         tx_level_ff <= (count_ff <= {1'b0, buffer_level_threshold_ff});
      end
   end

   // Two-entry buffer so a modulator stall never drops a fetched byte
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         skid_cnt_ff     <= 2'h0;
         skid_data_ff[0] <= 8'h00;
         skid_data_ff[1] <= 8'h00;
      end else begin
         if (take) begin
            skid_data_ff[0] <= skid_data_ff[1];
         end
         if (pop_tx) begin
            skid_data_ff[{1'b0, take} == skid_cnt_ff ? 1'b0 : 1'b1] <= fifo_mem[rd_ptr_ff];
         end
         skid_cnt_ff <= skid_cnt_ff + 2'(pop_tx) - 2'(take);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         tx_byte_o       <= 8'h00;
         tx_byte_valid_o <= 1'b0;
         tx_bit_o        <= 1'b0;
      end else begin
         tx_byte_o       <= skid_data_ff[0];
         tx_byte_valid_o <= (skid_cnt_ff != 2'h0) && !(tx_byte_valid_o && tx_byte_ready_i);
         tx_bit_o        <= state_tx && !buffered_path_select_ff && pin_ff[3];
      end
   end

   // Pin drivers and reference clock output
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ref_cnt_ff                  <= 16'h0000;
         reference_clock_output_o    <= 1'b0;
         reference_clock_output_oe_o <= 1'b0;
         irq_pin_a_o                 <= 1'b0;
         irq_pin_a_oe_o              <= 1'b0;
         irq_pin_b_o                 <= 1'b0;
         irq_pin_b_oe_o              <= 1'b0;
         data_pin_o                  <= 1'b0;
         data_pin_oe_o               <= 1'b0;
         sdo_oe_o                    <= 1'b0;
         sdo_from_buffer_o           <= 1'b0;
      end else begin
         if (ref_cnt_ff == 16'(REFCLK_DIV - 1)) begin
            ref_cnt_ff               <= 16'h0000;
            reference_clock_output_o <= !reference_clock_output_o;
         end else begin
            ref_cnt_ff <= ref_cnt_ff + 16'h0001;
         end
         reference_clock_output_oe_o <= (chip_state_select_ff != RMC_ST_SLEEP);
         irq_pin_a_oe_o <= (chip_state_select_ff != RMC_ST_SLEEP);
         irq_pin_b_oe_o <= (chip_state_select_ff != RMC_ST_SLEEP);
         if (buffered_path_select_ff) begin
            irq_pin_a_o <= rx_level_ff;
            irq_pin_b_o <= tx_level_ff;
         end else begin
            irq_pin_a_o <= 1'b0;
            irq_pin_b_o <= state_rx && rec_clk_ff;
         end
         data_pin_oe_o <= state_rx && !buffered_path_select_ff;
         data_pin_o    <= state_rx && rec_data_ff;
         sdo_oe_o      <= !config_port_select_n_i || !buffer_port_select_n_i;
         sdo_from_buffer_o <= config_port_select_n_i && !buffer_port_select_n_i;
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import rmc_pkg::*;
   logic clk = 0, rst_n = 0, hsel = 0, hw = 0, pll = 0, il = 0, ql = 0, cs = 1, bs = 1, hb = 0;
   logic [1:0] ht = 2'h0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, v;
   logic hro, dw, lb, lk, xe, se, re, te, bclk, dpo, doe, oe_a, oe_b, oe_c, sdo, sfb;
   logic [2:0] cnt = 3'h0;
   int n_errors = 0, checks_done = 0;
   always #50 clk = ~clk;
   // FSK source: I toggles every four cycles, one full period per eight-cycle bit
   always @(posedge clk) begin
      cnt <= cnt + 3'h1;
      il <= cnt[2];
   end
   rmc_radio_ctrl #(.BIT_CYCLES(8)) uut (.sys_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel),
      .haddr_i(ha), .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2), .hready_i(hro),
      .hwdata_i(hwd), .hrdata_o(hrd), .hreadyout_o(hro), .hresp_o(), .pll_locked_i(pll),
      .i_limited_i(il), .q_limited_i(ql), .signal_strength_value_i(8'h00),
      .config_port_select_n_i(cs), .buffer_port_select_n_i(bs), .xtal_en_o(xe),
      .synth_en_o(se), .rx_en_o(re), .tx_en_o(te), .lock_pin_o(lk), .irq_pin_a_o(),
      .irq_pin_a_oe_o(oe_a), .irq_pin_b_o(bclk), .irq_pin_b_oe_o(oe_b), .data_pin_i(dw),
      .data_pin_o(dpo), .data_pin_oe_o(doe), .reference_clock_output_o(),
      .reference_clock_output_oe_o(oe_c), .sdo_oe_o(sdo), .sdo_from_buffer_o(sfb),
      .tx_bit_o(), .tx_byte_o(), .tx_byte_valid_o(), .tx_byte_ready_i(1'b0));
   rmc_host_model host (.bit_clk_i(bclk), .data_o_i(dpo), .data_oe_i(doe),
      .host_bit_i(hb), .data_wire_o(dw), .last_bit_o(lb));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One single AHB transfer; waits on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1;
      ht <= 2'h2;
      hw <= w;
      ha <= {24'h0, a};
      @(posedge clk);
      while (hro !== 1'b1) @(posedge clk);
      hsel <= 0;
      ht <= 2'h0;
      hwd <= d;
      @(posedge clk);
      while (hro !== 1'b1) @(posedge clk);
      v = hrd;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(0, a, 32'h0);
      chk(v & m, e);
   endtask
   task automatic t_modes;
      for (int k = 0; k < 6; k++) begin
         bus(1, RMC_OFS_MODE, 32'(k) << 5);
         repeat (3) @(posedge clk);
         chk({xe, se, re, te}, k == 5 ? 4'hD : {k != 0, k >= 2, k == 3, k == 4});
      end
   endtask
   task automatic t_lock;
      pll <= 1;
      repeat (8) @(posedge clk);
      chk(lk, 1);
      pll <= 0;
      repeat (8) @(posedge clk);
      rd(RMC_OFS_LOCK, 32'h3, 32'h3);
      bus(1, RMC_OFS_LOCK, 32'h2);
      pll <= 1;
      repeat (8) @(posedge clk);
      chk(lk, 0);
      rd(RMC_OFS_LOCK, 32'h3, 32'h2);
   endtask
   task automatic t_sdo;
      for (int k = 0; k < 4; k++) begin
         cs <= k[1];
         bs <= k[0];
         repeat (2) @(posedge clk);
         chk({sdo, sfb}, {k != 3, k == 2});
      end
   endtask
   task automatic t_fifo;
      bus(1, RMC_OFS_MODE, 32'h20);
      bus(1, RMC_OFS_FIFOCFG, 32'h02);
      rd(RMC_OFS_STATUS, 32'h1E0, 32'h100);
      for (int k = 0; k < 17; k++) bus(1, RMC_OFS_FIFODAT, 32'(k));
      rd(RMC_OFS_STATUS, 32'hFFE0, 32'h20E0);
      for (int k = 0; k < 16; k++) rd(RMC_OFS_FIFODAT, 32'hFF, 32'(k));
      rd(RMC_OFS_STATUS, 32'hFFE0, 32'h100);
   endtask
   task automatic t_cont;
      bus(1, RMC_OFS_MODE, 32'h60);
      for (int k = 0; k < 2; k++) begin
         ql <= !k[0];
         repeat (48) @(posedge clk);
         chk({doe, lb}, {1'b1, !k[0]});
      end
      bus(1, RMC_OFS_RXCFG, 32'h40);
      repeat (16) @(posedge clk);
      chk(bclk, 0);
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Run is under three hundred cycles; about seventy times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk({oe_a, oe_b, oe_c, doe}, 0);
      rd(RMC_OFS_FIFOCFG, 32'hFF, 32'hE0);
      rd(8'h24, 32'hFF, 32'h0);
      t_modes;
      t_lock;
      t_sdo;
      t_fifo;
      t_cont;
      print_verdict;
   end
endmodule
`default_nettype wire
